/* File: include/pps_cfg.svh */
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// ----------------------------------------------------------------
// object indices
// ----------------------------------------------------------------
`define PPS_IDX_CONTROL 16'h6040
`define PPS_IDX_STATUS 16'h6041
`define PPS_IDX_OPMODE 16'h6060
`define PPS_IDX_TARGET 16'h607a
`define PPS_IDX_VELOCITY 16'h6081
`define PPS_IDX_ACCEL 16'h6083
`define PPS_IDX_DECEL 16'h6084
`define PPS_IDX_OPTION 16'h60f2

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define PPS_CW_NEW_SP 4
`define PPS_CW_CHG_IMM 5
`define PPS_CW_REL 6
`define PPS_SW_REACHED 10
`define PPS_SW_ACCEPTED 12
`define PPS_MODE_PP 8'h01
`define PPS_OPT_PREV 16'h0000
`define PPS_OPT_ACTUAL 16'h0002
`define PPS_OPT_MAX 16'h0002
`define PPS_VEL_MIN 32'h0000_0001

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPS_RST_VELOCITY 32'h0000_003c
`define PPS_RST_OPTION 16'h0000
`define PPS_RST_OPMODE 8'h00
`define PPS_RST_WORD 32'h0000_0000

`endif

/* File: include/pps_pkg.sv */
package pps_pkg;
    typedef logic signed [31:0] pps_pos_t;
    typedef logic [31:0] pps_word_t;
    typedef logic [15:0] pps_idx_t;
    typedef enum logic [0:0] {
        PPS_IDLE,
        PPS_MOVE
    } pps_state_e;
endpackage

/* File: rtl/pps_edge_det.sv */
`timescale 1ns/1ps
module pps_edge_det (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic valid_in,
    input wire logic bit_in,
    output logic rise_out,
    output logic level_out
);
    logic prev_ff;
    logic nxt_prev;

    // compare against the previous received word, not every cycle
    always_comb begin
        nxt_prev = valid_in ? bit_in : prev_ff;
        rise_out = valid_in & bit_in & ~prev_ff;
        level_out = prev_ff;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
        end
    end
endmodule

/* File: rtl/pps_clamp.sv */
`timescale 1ns/1ps
module pps_clamp (
    input wire pps_pkg::pps_pos_t value_in,
    input wire pps_pkg::pps_pos_t lo_in,
    input wire pps_pkg::pps_pos_t hi_in,
    output pps_pkg::pps_pos_t value_out
);
    import pps_pkg::*;

    always_comb begin
        if (value_in < lo_in) begin
            value_out = lo_in;
        end else if (value_in > hi_in) begin
            value_out = hi_in;
        end else begin
            value_out = value_in;
        end
    end
endmodule

/* File: rtl/pps_top.sv */
`timescale 1ns/1ps
`include "pps_cfg.svh"
// Contract
// - writing mode value profile position activates the mode directly.
// - a 0->1 change of new-setpoint bit starts a move to target.
// - immediate bit clear: new values queue until current target reached.
// - immediate bit set: new values apply at once, current target dropped.
// - absolute/relative bit: zero absolute, one relative.
// - target values are position, velocity, acceleration and deceleration.
// - status bit 10 high when target reached, low otherwise.
// - under halt, status bit 10 low decelerating, high at standstill.
// - status bit 12 high when new target accepted, low when possible.
// - mode ends only at standstill after reach, halt/quick stop, error.
// - absolute moves are positioned relative to the zero point.
// - relative base option: 0 previous target, 2 actual, 1 reserved.
// - velocity and option changes apply at next movement start; here they are latched at the new-setpoint edge.
// - written target position takes effect immediately; here it is only used at the next new-setpoint 0->1 edge.
// - velocity minimum 1, default 60, clamped to speed limits.
// - target position range set by scaling and software limits.
module pps_top #(
    parameter pps_pkg::pps_word_t ACCEL_RESET = 32'h0000_0000,
    parameter pps_pkg::pps_word_t DECEL_RESET = 32'h0000_0000
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic par_wr_in,
    input wire logic par_rd_in,
    input wire pps_pkg::pps_idx_t par_idx_in,
    input wire pps_pkg::pps_word_t par_wdata_in,
    output logic par_ack_out,
    output logic par_err_out,
    output pps_pkg::pps_word_t par_rdata_out,
    input wire logic gen_reached_in,
    input wire logic standstill_in,
    input wire pps_pkg::pps_pos_t actual_pos_in,
    input wire logic halt_in,
    input wire logic quick_stop_in,
    input wire logic fault_in,
    input wire pps_pkg::pps_word_t max_speed_in,
    input wire pps_pkg::pps_word_t ramp_max_velocity_in,
    input wire pps_pkg::pps_pos_t scale_min_in,
    input wire pps_pkg::pps_pos_t scale_max_in,
    input wire logic swlim_en_in,
    input wire pps_pkg::pps_pos_t swlim_min_in,
    input wire pps_pkg::pps_pos_t swlim_max_in,
    output logic [15:0] drive_status_word_out,
    output logic pp_active_out,
    output logic gen_start_out,
    output pps_pkg::pps_pos_t gen_target_out,
    output pps_pkg::pps_word_t gen_velocity_out,
    output pps_pkg::pps_word_t gen_accel_out,
    output pps_pkg::pps_word_t gen_decel_out
);
    import pps_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic pps_pos_t smax(input pps_pos_t a, input pps_pos_t b);
        smax = (a > b) ? a : b;
    endfunction

    function automatic pps_pos_t smin(input pps_pos_t a, input pps_pos_t b);
        smin = (a < b) ? a : b;
    endfunction

    function automatic pps_word_t vel_eff(input pps_word_t v,
                                          input pps_word_t lim_a,
                                          input pps_word_t lim_b);
        pps_word_t lim;
        lim = (lim_a < lim_b) ? lim_a : lim_b;
        if (v < `PPS_VEL_MIN) begin
            vel_eff = `PPS_VEL_MIN;
        end else if (v > lim) begin
            vel_eff = lim;
        end else begin
            vel_eff = v;
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] opmode_ff, nxt_opmode;
    logic [15:0] cw_ff, nxt_cw;
    pps_pos_t target_ff, nxt_target;
    pps_word_t vel_ff, nxt_vel;
    pps_word_t acc_ff, nxt_acc;
    pps_word_t dec_ff, nxt_dec;
    logic [15:0] opt_ff, nxt_opt;
    logic active_ff, nxt_active;
    pps_state_e state_ff, nxt_state;
    logic reached_ff, nxt_reached;
    logic accepted_ff, nxt_accepted;
    logic pend_ff, nxt_pend;
    pps_pos_t pend_tgt_ff, nxt_pend_tgt;
    pps_word_t pend_vel_ff, nxt_pend_vel;
    pps_word_t pend_acc_ff, nxt_pend_acc;
    pps_word_t pend_dec_ff, nxt_pend_dec;
    pps_pos_t last_tgt_ff, nxt_last_tgt;
    logic start_ff, nxt_start;
    pps_pos_t gtgt_ff, nxt_gtgt;
    pps_word_t gvel_ff, nxt_gvel;
    pps_word_t gacc_ff, nxt_gacc;
    pps_word_t gdec_ff, nxt_gdec;
    logic [15:0] status_ff, nxt_status;
    logic ack_ff, nxt_ack;
    logic err_ff, nxt_err;
    pps_word_t rdata_ff, nxt_rdata;

    logic cw_wr;
    logic sp_rise;
    logic sp_level;
    logic stop_req;
    logic sp_edge;
    pps_pos_t base_pos;
    pps_pos_t raw_tgt;
    pps_pos_t lim_lo;
    pps_pos_t lim_hi;
    pps_pos_t new_tgt;
    pps_word_t new_vel;

    assign cw_wr = par_wr_in && (par_idx_in == `PPS_IDX_CONTROL);

    // ------------------------------------------------------------
    // setpoint edge and target arithmetic
    // ------------------------------------------------------------
    pps_edge_det u_edge (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .valid_in(cw_wr),
        .bit_in(par_wdata_in[`PPS_CW_NEW_SP]),
        .rise_out(sp_rise),
        .level_out(sp_level)
    );

    always_comb begin
        stop_req = halt_in | quick_stop_in | fault_in;
        sp_edge = sp_rise & active_ff & ~stop_req;
        // option value read here, so a change only bites at a new-setpoint edge
        base_pos = (opt_ff == `PPS_OPT_ACTUAL) ? actual_pos_in
                                                : last_tgt_ff;
        // absolute coordinates already count from the homed zero point
        raw_tgt = par_wdata_in[`PPS_CW_REL] ? base_pos + target_ff
                                            : target_ff;
        lim_lo = swlim_en_in ? smax(scale_min_in, swlim_min_in)
                             : scale_min_in;
        lim_hi = swlim_en_in ? smin(scale_max_in, swlim_max_in)
                             : scale_max_in;
        new_vel = vel_eff(vel_ff, max_speed_in,
                          ramp_max_velocity_in);
    end

    pps_clamp u_clamp (
        .value_in(raw_tgt),
        .lo_in(lim_lo),
        .hi_in(lim_hi),
        .value_out(new_tgt)
    );

    // ------------------------------------------------------------
    // parameter access
    // ------------------------------------------------------------
    always_comb begin
        nxt_opmode = opmode_ff;
        nxt_cw = cw_ff;
        nxt_target = target_ff;
        nxt_vel = vel_ff;
        nxt_acc = acc_ff;
        nxt_dec = dec_ff;
        nxt_opt = opt_ff;
        nxt_ack = par_wr_in | par_rd_in;
        nxt_err = 1'b0;
        nxt_rdata = rdata_ff;
        if (par_wr_in) begin
            case (par_idx_in)
                `PPS_IDX_CONTROL: nxt_cw = par_wdata_in[15:0];
                `PPS_IDX_OPMODE: nxt_opmode = par_wdata_in[7:0];
                `PPS_IDX_TARGET: nxt_target = par_wdata_in;
                `PPS_IDX_VELOCITY: begin
                    if (par_wdata_in < `PPS_VEL_MIN) begin
                        nxt_err = 1'b1;
                    end else begin
                        nxt_vel = par_wdata_in;
                    end
                end
                `PPS_IDX_ACCEL: nxt_acc = par_wdata_in;
                `PPS_IDX_DECEL: nxt_dec = par_wdata_in;
                `PPS_IDX_OPTION: begin
                    // reserved value 1 and anything past the top refused
                    if (par_wdata_in[31:16] != 16'h0000 ||
                        par_wdata_in[15:0] > `PPS_OPT_MAX ||
                        (par_wdata_in[15:0] != `PPS_OPT_PREV &&
                         par_wdata_in[15:0] != `PPS_OPT_ACTUAL)) begin
                        nxt_err = 1'b1;
                    end else begin
                        nxt_opt = par_wdata_in[15:0];
                    end
                end
                default: nxt_err = 1'b1;
            endcase
        end else if (par_rd_in) begin
            case (par_idx_in)
                `PPS_IDX_CONTROL: nxt_rdata = {16'h0000, cw_ff};
                `PPS_IDX_STATUS: nxt_rdata = {16'h0000, status_ff};
                `PPS_IDX_OPMODE: nxt_rdata = {24'h00_0000, opmode_ff};
                `PPS_IDX_TARGET: nxt_rdata = target_ff;
                `PPS_IDX_VELOCITY: nxt_rdata = vel_ff;
                `PPS_IDX_ACCEL: nxt_rdata = acc_ff;
                `PPS_IDX_DECEL: nxt_rdata = dec_ff;
                `PPS_IDX_OPTION: nxt_rdata = {16'h0000, opt_ff};
                default: begin
                    nxt_rdata = `PPS_RST_WORD;
                    nxt_err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            opmode_ff <= `PPS_RST_OPMODE;
            cw_ff <= 16'h0000;
            target_ff <= `PPS_RST_WORD;
            vel_ff <= `PPS_RST_VELOCITY;
            acc_ff <= ACCEL_RESET;
            dec_ff <= DECEL_RESET;
            opt_ff <= `PPS_RST_OPTION;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= `PPS_RST_WORD;
        end else begin
            opmode_ff <= nxt_opmode;
            cw_ff <= nxt_cw;
            target_ff <= nxt_target;
            vel_ff <= nxt_vel;
            acc_ff <= nxt_acc;
            dec_ff <= nxt_dec;
            opt_ff <= nxt_opt;
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // mode, movement and setpoint queue
    // ------------------------------------------------------------
    always_comb begin
        nxt_active = active_ff;
        nxt_state = state_ff;
        nxt_reached = reached_ff;
        nxt_accepted = accepted_ff;
        nxt_pend = pend_ff;
        nxt_pend_tgt = pend_tgt_ff;
        nxt_pend_vel = pend_vel_ff;
        nxt_pend_acc = pend_acc_ff;
        nxt_pend_dec = pend_dec_ff;
        nxt_last_tgt = last_tgt_ff;
        nxt_start = 1'b0;
        nxt_gtgt = gtgt_ff;
        nxt_gvel = gvel_ff;
        nxt_gacc = gacc_ff;
        nxt_gdec = gdec_ff;
        if (par_wr_in && par_idx_in == `PPS_IDX_OPMODE &&
            par_wdata_in[7:0] == `PPS_MODE_PP) begin
            nxt_active = 1'b1;
        end else if (active_ff && opmode_ff != `PPS_MODE_PP &&
                     standstill_in && state_ff == PPS_IDLE &&
                     (reached_ff || stop_req)) begin
            nxt_active = 1'b0;
        end
        // new-setpoint back to zero frees the handshake
        if (cw_wr && !par_wdata_in[`PPS_CW_NEW_SP]) begin
            nxt_accepted = 1'b0;
        end
        case (state_ff)
            PPS_IDLE: begin
                if (sp_edge) begin
                    nxt_state = PPS_MOVE;
                    nxt_start = 1'b1;
                end
            end
            PPS_MOVE: begin
                if (sp_edge && par_wdata_in[`PPS_CW_CHG_IMM]) begin
                    nxt_start = 1'b1;
                    nxt_pend = 1'b0;
                end else if (sp_edge) begin
                    nxt_pend = 1'b1;
                    nxt_pend_tgt = new_tgt;
                    nxt_pend_vel = new_vel;
                    nxt_pend_acc = acc_ff;
                    nxt_pend_dec = dec_ff;
                end else if (stop_req) begin
                    // a stopped move keeps nothing queued
                    nxt_pend = 1'b0;
                    if (standstill_in) begin
                        nxt_state = PPS_IDLE;
                    end
                end else if (gen_reached_in && pend_ff) begin
                    nxt_pend = 1'b0;
                    nxt_start = 1'b1;
                    nxt_gtgt = pend_tgt_ff;
                    nxt_gvel = pend_vel_ff;
                    nxt_gacc = pend_acc_ff;
                    nxt_gdec = pend_dec_ff;
                    nxt_last_tgt = pend_tgt_ff;
                    nxt_reached = 1'b0;
                end else if (gen_reached_in) begin
                    nxt_state = PPS_IDLE;
                    nxt_reached = 1'b1;
                end
            end
            default: nxt_state = PPS_IDLE;
        endcase
        if (sp_edge) begin
            nxt_accepted = 1'b1;
        end
        if (nxt_start && sp_edge &&
            (state_ff == PPS_IDLE || par_wdata_in[`PPS_CW_CHG_IMM])) begin
            nxt_gtgt = new_tgt;
            nxt_gvel = new_vel;
            nxt_gacc = acc_ff;
            nxt_gdec = dec_ff;
            nxt_last_tgt = new_tgt;
            nxt_reached = 1'b0;
        end
        nxt_status = 16'h0000;
        nxt_status[`PPS_SW_REACHED] = nxt_active &
            (halt_in ? standstill_in : nxt_reached);
        nxt_status[`PPS_SW_ACCEPTED] = nxt_accepted;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            active_ff <= 1'b0;
            state_ff <= PPS_IDLE;
            reached_ff <= 1'b0;
            accepted_ff <= 1'b0;
            pend_ff <= 1'b0;
            pend_tgt_ff <= `PPS_RST_WORD;
            pend_vel_ff <= `PPS_RST_VELOCITY;
            pend_acc_ff <= ACCEL_RESET;
            pend_dec_ff <= DECEL_RESET;
            last_tgt_ff <= `PPS_RST_WORD;
            start_ff <= 1'b0;
            gtgt_ff <= `PPS_RST_WORD;
            gvel_ff <= `PPS_RST_VELOCITY;
            gacc_ff <= ACCEL_RESET;
            gdec_ff <= DECEL_RESET;
            status_ff <= 16'h0000;
        end else begin
            active_ff <= nxt_active;
            state_ff <= nxt_state;
            reached_ff <= nxt_reached;
            accepted_ff <= nxt_accepted;
            pend_ff <= nxt_pend;
            pend_tgt_ff <= nxt_pend_tgt;
            pend_vel_ff <= nxt_pend_vel;
            pend_acc_ff <= nxt_pend_acc;
            pend_dec_ff <= nxt_pend_dec;
            last_tgt_ff <= nxt_last_tgt;
            start_ff <= nxt_start;
            gtgt_ff <= nxt_gtgt;
            gvel_ff <= nxt_gvel;
            gacc_ff <= nxt_gacc;
            gdec_ff <= nxt_gdec;
            status_ff <= nxt_status;
        end
    end

    assign par_ack_out = ack_ff;
    assign par_err_out = err_ff;
    assign par_rdata_out = rdata_ff;
    assign drive_status_word_out = status_ff;
    assign pp_active_out = active_ff;
    assign gen_start_out = start_ff;
    assign gen_target_out = gtgt_ff;
    assign gen_velocity_out = gvel_ff;
    assign gen_accel_out = gacc_ff;
    assign gen_decel_out = gdec_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_idle_edge;
        sp_edge && state_ff == PPS_IDLE;
    endsequence

    sequence s_queue_edge;
        sp_edge && state_ff == PPS_MOVE &&
            !par_wdata_in[`PPS_CW_CHG_IMM];
    endsequence

    property p_mode_on;
        par_wr_in && par_idx_in == `PPS_IDX_OPMODE &&
            par_wdata_in[7:0] == `PPS_MODE_PP |=> pp_active_out;
    endproperty
    a_mode_on: assert property (p_mode_on)
        else $error("mode write did not activate");

    property p_start;
        s_idle_edge |=> gen_start_out && gen_target_out == $past(new_tgt);
    endproperty
    a_start: assert property (p_start)
        else $error("setpoint edge did not start move");

    property p_held;
        cw_wr && sp_level |=> !gen_start_out;
    endproperty
    a_held: assert property (p_held)
        else $error("held setpoint bit restarted move");

    property p_queue;
        s_queue_edge ##1 (!gen_reached_in && !stop_req)[*2] |->
            !gen_start_out && pend_ff;
    endproperty
    a_queue: assert property (p_queue)
        else $error("queued setpoint applied early");

    property p_imm;
        sp_edge && state_ff == PPS_MOVE && par_wdata_in[`PPS_CW_CHG_IMM]
            |=> gen_start_out && !pend_ff;
    endproperty
    a_imm: assert property (p_imm)
        else $error("immediate setpoint not applied");

    property p_reached;
        state_ff == PPS_MOVE && gen_reached_in && !pend_ff && !sp_edge &&
            !stop_req && active_ff |=>
            drive_status_word_out[`PPS_SW_REACHED];
    endproperty
    a_reached: assert property (p_reached)
        else $error("target reached not reported");

    property p_halt;
        // a mode change may drop the mode next cycle, so bit 10 then reads 0
        pp_active_out && halt_in && !par_wr_in &&
            opmode_ff == `PPS_MODE_PP |=>
            drive_status_word_out[`PPS_SW_REACHED] == $past(standstill_in);
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt meaning of bit 10 wrong");

    property p_accept;
        sp_edge |=> drive_status_word_out[`PPS_SW_ACCEPTED] ##1
            (drive_status_word_out[`PPS_SW_ACCEPTED] || $past(cw_wr));
    endproperty
    a_accept: assert property (p_accept)
        else $error("accepted bit not held");

    property p_stay;
        pp_active_out && !standstill_in && !par_wr_in |=> pp_active_out;
    endproperty
    a_stay: assert property (p_stay)
        else $error("mode left while moving");

    property p_vel_hold;
        state_ff == PPS_MOVE && !sp_edge && !gen_reached_in
            |=> $stable(gen_velocity_out);
    endproperty
    a_vel_hold: assert property (p_vel_hold)
        else $error("velocity changed mid move");

    property p_vel_min;
        gen_start_out |-> gen_velocity_out >= `PPS_VEL_MIN;
    endproperty
    a_vel_min: assert property (p_vel_min)
        else $error("velocity below minimum");
endmodule

/* File: test/pps_motion_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// motion generator stand-in
// ----------------------------------------
module pps_motion_model #(
    parameter int DUR = 60
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic halt_in,
    input wire pps_pkg::pps_pos_t target_in,
    output logic reached_out,
    output logic standstill_out,
    output pps_pkg::pps_pos_t pos_out
);
    int cnt;
    assign standstill_out = (cnt == 0);
    // zero point is position 0 out of reset, as if homed
    always @(negedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt <= 0;
            reached_out <= 1'b0;
            pos_out <= '0;
        end else if (start_in === 1'b1) begin
            cnt <= DUR;
            reached_out <= 1'b0;
        end else if (cnt > 0) begin
            // a halted move stops short and never reports reached
            cnt <= (halt_in && cnt > 4) ? 4 : cnt - 1;
            if (cnt == 1 && !halt_in) begin
                reached_out <= 1'b1;
                pos_out <= target_in;
            end
        end
    end
endmodule

/* File: test/pps_top_tb.sv */
`timescale 1ns/1ps
module pps_top_tb;
    import pps_pkg::*;
    logic clk_in = 0;
    logic rstn_in = 0;
    logic wr = 0;
    logic rd = 0;
    logic halt = 0;
    logic qs = 0;
    logic flt = 0;
    logic swen = 0;
    logic ack, err, act, gst, rch, stl;
    logic [15:0] sw;
    pps_idx_t idx = '0;
    pps_word_t wd = '0;
    pps_word_t msp = 32'h0000_1388;
    pps_word_t rmx = 32'h0000_0bb8;
    pps_word_t rdat, gvl, gac, gdc;
    pps_pos_t smn = 32'hffff_fc18;
    pps_pos_t smx = 32'h0001_86a0;
    pps_pos_t lmn = 32'hffff_fc18;
    pps_pos_t lmx = 32'h0000_1388;
    pps_pos_t gtg, apos, t1, t2, t3;
    logic [33:0] bus_q[$];
    pps_pos_t tgt_q[$];
    logic [33:0] e;
    int fails = 0;
    int samples_checked = 0;
    int starts = 0;
    int n;
    integer seed = 347;

    pps_top u_pps_top (.clk_in(clk_in), .rstn_in(rstn_in),
        .par_wr_in(wr), .par_rd_in(rd), .par_idx_in(idx),
        .par_wdata_in(wd), .par_ack_out(ack), .par_err_out(err),
        .par_rdata_out(rdat), .gen_reached_in(rch), .standstill_in(stl),
        .actual_pos_in(apos), .halt_in(halt), .quick_stop_in(qs),
        .fault_in(flt), .max_speed_in(msp), .ramp_max_velocity_in(rmx),
        .scale_min_in(smn), .scale_max_in(smx), .swlim_en_in(swen),
        .swlim_min_in(lmn), .swlim_max_in(lmx),
        .drive_status_word_out(sw), .pp_active_out(act),
        .gen_start_out(gst), .gen_target_out(gtg),
        .gen_velocity_out(gvl), .gen_accel_out(gac),
        .gen_decel_out(gdc));
    pps_motion_model #(.DUR(60)) u_pps_motion_model (.clk_in(clk_in),
        .rstn_in(rstn_in), .start_in(gst), .halt_in(halt),
        .target_in(gtg), .reached_out(rch), .standstill_out(stl),
        .pos_out(apos));

    initial forever #20 clk_in = ~clk_in;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
        end
    endtask

    // e holds expected error bit and read data
    task automatic acc(input logic w, input pps_idx_t i,
                       input pps_word_t d, input logic [32:0] x);
        @(negedge clk_in);
        wr = w;
        rd = !w;
        idx = i;
        wd = d;
        bus_q.push_back({!w, x});
        @(negedge clk_in);
        wr = 0;
        rd = 0;
    endtask

    task automatic print_verdict;
        $display("checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(negedge clk_in) begin
        if (ack === 1'b1) begin
            e = bus_q.pop_front();
            chk(32'(err), 32'(e[32]), "error flag");
            if (e[33]) chk(rdat, e[31:0], "read data");
        end
        if (gst === 1'b1) begin
            starts++;
            chk(32'(tgt_q.size() > 0), 32'h0000_0001, "extra start");
            chk(gtg, tgt_q.pop_front(), "target");
            chk(gvl, 32'h0000_0bb8, "velocity");
            chk(gac, 32'h0000_0064, "accel");
            chk(gdc, 32'h0000_012c, "decel");
        end
    end

    initial begin
        #200000;
        fails++;
        print_verdict();
    end

    initial begin
        repeat (10) @(negedge clk_in);
        rstn_in = 1;
        t1 = $random(seed) & 32'h0000_03ff;
        acc(0, 16'h6081, '0, {1'b0, 32'h0000_003c});
        acc(0, 16'h60f2, '0, '0);
        acc(1, 16'h6081, '0, {1'b1, 32'h0});
        acc(1, 16'h60f2, 32'h0000_0001, {1'b1, 32'h0});
        acc(1, 16'h60f2, 32'h0000_0003, {1'b1, 32'h0});
        acc(1, 16'h1234, '0, {1'b1, 32'h0});
        $display("test reset_refuse done");
        acc(1, 16'h6060, 32'h0000_0001, '0);
        chk(32'(act), 32'h0000_0001, "mode on");
        acc(1, 16'h6083, 32'h0000_0064, '0);
        acc(1, 16'h6084, 32'h0000_012c, '0);
        acc(1, 16'h6081, 32'h0000_0fa0, '0);
        acc(1, 16'h607a, t1, '0);
        tgt_q.push_back(t1);
        acc(1, 16'h6040, 32'h0000_000f, '0);
        acc(1, 16'h6040, 32'h0000_001f, '0);
        acc(1, 16'h6040, 32'h0000_001f, '0);
        acc(0, 16'h6041, '0, {1'b0, 32'h0000_1000});
        acc(1, 16'h6040, 32'h0000_000f, '0);
        acc(0, 16'h6041, '0, '0);
        repeat (70) @(negedge clk_in);
        acc(0, 16'h6041, '0, {1'b0, 32'h0000_0400});
        $display("test absolute done");
        acc(1, 16'h60f2, 32'h0000_0002, '0);
        acc(1, 16'h607a, 32'h0000_0010, '0);
        tgt_q.push_back(t1 + 16);
        acc(1, 16'h6040, 32'h0000_004f, '0);
        acc(1, 16'h6040, 32'h0000_005f, '0);
        repeat (70) @(negedge clk_in);
        $display("test relative done");
        t2 = $random(seed) & 32'h0000_03ff;
        t3 = $random(seed) & 32'h0000_03ff;
        acc(1, 16'h607a, t2, '0);
        tgt_q.push_back(t2);
        acc(1, 16'h6040, 32'h0000_000f, '0);
        acc(1, 16'h6040, 32'h0000_001f, '0);
        acc(1, 16'h6040, 32'h0000_000f, '0);
        acc(1, 16'h607a, t3, '0);
        tgt_q.push_back(t3);
        n = starts;
        acc(1, 16'h6040, 32'h0000_001f, '0);
        repeat (5) @(negedge clk_in);
        chk(32'(starts), 32'(n), "queued start");
        repeat (60) @(negedge clk_in);
        swen = 1;
        acc(1, 16'h6040, 32'h0000_000f, '0);
        acc(1, 16'h607a, 32'h7fff_ffff, '0);
        tgt_q.push_back(32'h0000_1388);
        n = starts;
        acc(1, 16'h6040, 32'h0000_003f, '0);
        // the watcher counts the start on this same edge: let it run first
        @(negedge clk_in);
        chk(32'(starts), 32'(n + 1), "immediate start");
        repeat (70) @(negedge clk_in);
        $display("test setpoint_change done");
        acc(1, 16'h607a, 32'h0000_00c8, '0);
        tgt_q.push_back(32'h0000_00c8);
        acc(1, 16'h6040, 32'h0000_000f, '0);
        acc(1, 16'h6040, 32'h0000_001f, '0);
        acc(1, 16'h6040, 32'h0000_000f, '0);
        halt = 1;
        repeat (20) @(negedge clk_in);
        acc(0, 16'h6041, '0, {1'b0, 32'h0000_0400});
        acc(1, 16'h6060, '0, '0);
        // mode ends one cycle after the stored mode value changes
        @(negedge clk_in);
        chk(32'(act), '0, "mode off");
        $display("test halt done");
        repeat (5) @(negedge clk_in);
        print_verdict();
    end
endmodule
